// file: hw/mcf_pkg.sv
// Package for the motion command frame handler: frame layout, status codes, timing.
// Assumes one 50 MHz clock shared by every user of the package.
package mcf_pkg;

  localparam int unsigned CORE_LEN = 7;
  localparam int unsigned SER_LEN = 9;
  localparam int unsigned REPLY_SER_LEN = 9;
  localparam int unsigned REPLY_CAN_LEN = 7;

  // Byte positions inside a serial command frame.
  localparam logic [3:0] POS_ADDR = 4'h0;
  localparam logic [3:0] POS_CMD = 4'h1;
  localparam logic [3:0] POS_TYPE = 4'h2;
  localparam logic [3:0] POS_BANK = 4'h3;
  localparam logic [3:0] POS_VAL0 = 4'h4;
  localparam logic [3:0] POS_CSUM = 4'h8;

  // Reply status codes.
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_STORED = 8'h65;
  localparam logic [7:0] ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;

  // Command and parameter numbers handled locally.
  localparam logic [7:0] CMD_SET_AXIS = 8'h05;
  localparam logic [7:0] CMD_GET_AXIS = 8'h06;
  localparam logic [7:0] PAR_STANDBY = 8'h07;
  localparam logic [7:0] STANDBY_RST = 8'h00;

  // Inter-byte gap after which a partial serial frame is dropped.
  localparam int unsigned GAP_US = 1000;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned GAP_CYC = GAP_US * CLK_MHZ;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
  } mcf_core_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mcf_byte_t;

  typedef enum logic [2:0] {
    S_RX = 3'b000,
    S_EXEC = 3'b001,
    S_WAIT = 3'b011,
    S_TX = 3'b010
  } mcf_state_t;

endpackage : mcf_pkg

// file: hw/mcf_gap_timer.sv
// Inter-byte gap timer: reports expiry when no byte arrives for LIMIT cycles.
// Assumes byte strobes on the same clock; runs only while armed.
`timescale 1ns/1ps
module mcf_gap_timer #(
  parameter int unsigned LIMIT = 50000
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Control.
  input wire logic armed,
  input wire logic kick,
  // Result.
  output logic expired
);

  if (LIMIT < 2 || LIMIT > 32'h00FF_FFFF) begin : g_bad_limit
    $error("mcf_gap_timer: LIMIT out of range");
  end

  typedef struct packed {
    logic [23:0] cnt;
    logic hit;
  } mcf_gap_st_t;

  mcf_gap_st_t st_r;
  mcf_gap_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    if (!armed || kick) begin
      st_nxt.cnt = 24'h00_0000;
    end else if (st_r.cnt == 24'(LIMIT - 1)) begin
      st_nxt.cnt = 24'h00_0000;
      st_nxt.hit = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 24'h00_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.hit;

endmodule : mcf_gap_timer

// file: hw/mcf_frame_handler.sv
// Command frame handler: receives one command frame for module_addr, executes it if its checksum holds, sends one reply.
// Assumes a byte link on the same clock (rx strobe, tx handshake) and an execution
// unit that answers each request with one done pulse carrying status and value.
`timescale 1ns/1ps

// Overview of operation
// - Core is cmd, type, bank, 32-bit value MSB-first.
// - Serial frames add address byte and checksum.
// - Checksum is 8-bit sum including address.
// - CAN frames carry no address or checksum.
// - Reply only after command processing completes.
// - Transmitter enabled only for replies, never unsolicited.
// - Standby current 0..255 held while stationary.
// - Serial reply: reply addr, addr, status, cmd, value, checksum.
// - Reply checksum is 8-bit sum of others.
// - CAN reply omits reply address and checksum.
// - Status codes 100,101,1,2,3,4.
module mcf_frame_handler #(
  parameter int unsigned GAP_LIMIT = mcf_pkg::GAP_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Configuration.
  input wire logic can_mode,
  input wire logic [7:0] module_addr,
  input wire logic [7:0] reply_addr,
  // Received byte stream.
  input wire mcf_pkg::mcf_byte_t rx,
  // Transmit byte stream.
  output mcf_pkg::mcf_byte_t tx,
  input wire logic tx_ready,
  output logic tx_enable,
  // Execution unit.
  output logic exec_req,
  output mcf_pkg::mcf_core_t exec_core,
  input wire logic exec_done,
  input wire logic [7:0] exec_status,
  input wire logic [31:0] exec_value,
  // Locally held setting.
  output logic [7:0] standby_current,
  output logic motor_idle_current_sel,
  input wire logic motor_moving
);

  typedef struct packed {
    mcf_pkg::mcf_state_t state;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [7:0] addr;
    mcf_pkg::mcf_core_t core;
    logic [7:0] status;
    logic [31:0] value;
    logic [7:0] standby;
    logic req;
    logic [7:0] txd;
  } mcf_st_t;

  mcf_st_t st_r;
  mcf_st_t st_nxt;
  logic gap_expired;
  logic [3:0] last_rx;
  logic [3:0] last_tx;
  logic [3:0] rx_pos;
  logic [3:0] rx_idx;
  logic [7:0] rx_sum;
  logic local_cmd;

  if (GAP_LIMIT < 2) begin : g_bad_gap
    $error("mcf_frame_handler: GAP_LIMIT too small");
  end

  mcf_gap_timer #(
    .LIMIT(GAP_LIMIT)
  ) i_mcf_gap_timer (
    .clock(clock),
    .srst(srst),
    .armed(st_r.state == mcf_pkg::S_RX && st_r.idx != 4'h0 && !can_mode),
    .kick(rx.valid),
    .expired(gap_expired)
  );

  // CAN frames start at the command byte, so shift the position by one.
  assign last_rx = can_mode ? 4'(mcf_pkg::CORE_LEN - 1) : 4'(mcf_pkg::SER_LEN - 1);
  assign last_tx = can_mode ? 4'(mcf_pkg::REPLY_CAN_LEN - 1)
                            : 4'(mcf_pkg::REPLY_SER_LEN - 1);
  // A byte that lands together with the gap expiry opens a new frame instead of being lost.
  assign rx_idx = gap_expired ? 4'h0 : st_r.idx;
  assign rx_sum = gap_expired ? 8'h00 : st_r.sum;
  assign rx_pos = can_mode ? rx_idx + 4'h1 : rx_idx;
  assign local_cmd = st_r.core.typ == mcf_pkg::PAR_STANDBY
                  && (st_r.core.cmd == mcf_pkg::CMD_SET_AXIS
                      || st_r.core.cmd == mcf_pkg::CMD_GET_AXIS);

  always_comb begin
    logic [3:0] p;
    p = 4'h0;
    st_nxt = st_r;
    st_nxt.req = 1'b0;
    unique case (st_r.state)
      mcf_pkg::S_RX: begin
        if (gap_expired) begin
          st_nxt.idx = 4'h0;
          st_nxt.sum = 8'h00;
        end
        if (rx.valid) begin
          st_nxt.idx = rx_idx + 4'h1;
          st_nxt.sum = rx_sum + rx.data;
          unique case (rx_pos)
            mcf_pkg::POS_ADDR: st_nxt.addr = rx.data;
            mcf_pkg::POS_CMD: st_nxt.core.cmd = rx.data;
            mcf_pkg::POS_TYPE: st_nxt.core.typ = rx.data;
            mcf_pkg::POS_BANK: st_nxt.core.bank = rx.data;
            mcf_pkg::POS_CSUM: ;
            default: st_nxt.core.value = {st_r.core.value[23:0], rx.data};
          endcase
          if (rx_idx == last_rx) begin
            st_nxt.idx = 4'h0;
            st_nxt.sum = 8'h00;
            if (can_mode) begin
              st_nxt.addr = module_addr;
              st_nxt.state = mcf_pkg::S_EXEC;
            end else if (st_r.addr != module_addr) begin
              st_nxt.state = mcf_pkg::S_RX;
            end else if (rx_sum != rx.data) begin
              st_nxt.status = mcf_pkg::ST_BAD_CSUM;
              st_nxt.value = st_r.core.value;
              st_nxt.state = mcf_pkg::S_TX;
              st_nxt.sum = 8'h00;
            end else begin
              st_nxt.state = mcf_pkg::S_EXEC;
            end
          end
        end
      end
      mcf_pkg::S_EXEC: begin
        if (local_cmd) begin
          if (st_r.core.cmd == mcf_pkg::CMD_SET_AXIS) begin
            if (st_r.core.value[31:8] != 24'h00_0000) begin
              st_nxt.status = mcf_pkg::ST_BAD_VALUE;
            end else begin
              st_nxt.standby = st_r.core.value[7:0];
              st_nxt.status = mcf_pkg::ST_OK;
            end
            st_nxt.value = st_r.core.value;
          end else begin
            st_nxt.status = mcf_pkg::ST_OK;
            st_nxt.value = {24'h00_0000, st_r.standby};
          end
          st_nxt.state = mcf_pkg::S_TX;
        end else begin
          st_nxt.req = 1'b1;
          st_nxt.state = mcf_pkg::S_WAIT;
        end
      end
      mcf_pkg::S_WAIT: begin
        if (exec_done) begin
          st_nxt.status = exec_status;
          st_nxt.value = exec_value;
          st_nxt.state = mcf_pkg::S_TX;
        end
      end
      mcf_pkg::S_TX: begin
        if (tx_ready) begin
          st_nxt.idx = st_r.idx + 4'h1;
          st_nxt.sum = st_r.sum + st_r.txd;
          if (st_r.idx == last_tx) begin
            st_nxt.idx = 4'h0;
            st_nxt.sum = 8'h00;
            st_nxt.state = mcf_pkg::S_RX;
          end
        end
      end
      default: st_nxt.state = mcf_pkg::S_RX;
    endcase
    // The reply byte is registered for the position that the next cycle presents.
    // CAN replies drop the reply address and the checksum and open with the module address.
    p = can_mode ? st_nxt.idx + 4'h1 : st_nxt.idx;
    unique case (p)
      4'h0: st_nxt.txd = reply_addr;
      4'h1: st_nxt.txd = st_nxt.addr;
      4'h2: st_nxt.txd = st_nxt.status;
      4'h3: st_nxt.txd = st_nxt.core.cmd;
      4'h4: st_nxt.txd = st_nxt.value[31:24];
      4'h5: st_nxt.txd = st_nxt.value[23:16];
      4'h6: st_nxt.txd = st_nxt.value[15:8];
      4'h7: st_nxt.txd = st_nxt.value[7:0];
      4'h8: st_nxt.txd = st_nxt.sum;
      default: st_nxt.txd = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
      st_r.state <= mcf_pkg::S_RX;
      st_r.standby <= mcf_pkg::STANDBY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Transmitter drives the bus only while a reply is pending.
  assign tx_enable = st_r.state == mcf_pkg::S_TX;
  assign tx.valid = st_r.state == mcf_pkg::S_TX;
  assign tx.data = st_r.txd;
  assign exec_req = st_r.req;
  assign exec_core = st_r.core;
  assign standby_current = st_r.standby;
  assign motor_idle_current_sel = !motor_moving;

  // The host holds off its next command until the reply ends; bytes arriving
  // outside S_RX are dropped.

endmodule : mcf_frame_handler

// file: test/mcf_frame_sva.sv
// Port assertions for the command frame handler.
// Bound to mcf_frame_handler; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module mcf_frame_sva (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Byte link.
  input wire mcf_pkg::mcf_byte_t rx,
  input wire mcf_pkg::mcf_byte_t tx,
  input wire logic tx_ready,
  input wire logic tx_enable,
  // Execution unit and setting.
  input wire logic exec_req,
  input wire logic exec_done,
  input wire logic [7:0] standby_current,
  input wire logic motor_idle_current_sel,
  input wire logic motor_moving
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_stall; tx.valid && !tx_ready; endsequence
  sequence s_wait; exec_req ##1 !exec_done; endsequence
  property p_en; tx.valid |-> tx_enable; endproperty
  a_en: assert property (p_en) else $error("reply without enable");
  property p_hold; s_stall |=> tx.valid && $stable(tx.data); endproperty
  a_hold: assert property (p_hold) else $error("reply byte not held");
  property p_sel; motor_idle_current_sel == !motor_moving; endproperty
  a_sel: assert property (p_sel) else $error("idle current select wrong");
  property p_cause; exec_req |-> $past(rx.valid, 2); endproperty
  a_cause: assert property (p_cause) else $error("request without frame");
  property p_quiet; s_wait |-> !tx.valid ##1 !tx.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("reply before done");
  property p_done; exec_done && !tx_enable |=> tx.valid; endproperty
  a_done: assert property (p_done) else $error("no reply after done");
  property p_unsol;
    $rose(tx.valid) |-> $past(exec_done) || $past(rx.valid) || $past(rx.valid, 2);
  endproperty
  a_unsol: assert property (p_unsol) else $error("unsolicited reply");
  property p_stby; $changed(standby_current) |-> ##[0:2] tx.valid; endproperty
  a_stby: assert property (p_stby) else $error("standby change without reply");
endmodule : mcf_frame_sva

// file: test/mcf_host_model.sv
// Host model: sends command frames at the falling edge and collects the reply.
// Assumes the handler's byte link runs on the same clock.
`timescale 1ns/1ps
module mcf_host_model (
  // Clock.
  input wire logic clock,
  // Byte link.
  output mcf_pkg::mcf_byte_t rx,
  input wire mcf_pkg::mcf_byte_t tx,
  output logic tx_ready
);
  logic [7:0] rq[$];
  initial begin
    rx = '0;
    tx_ready = 1'b0;
  end
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(negedge clock);
      rx <= {1'b1, f[i]};
    end
    @(negedge clock);
    rx <= {1'b0, ~rx.data};
  endtask : send
  // Collects n reply bytes; the caller sends nothing new until this returns.
  task automatic get(input int n, input bit slow);
    logic r;
    rq = {};
    for (int k = 0; k < 400 && rq.size() < n; k++) begin
      @(negedge clock);
      r = slow ? k[0] : 1'b1;
      tx_ready <= r;
      if (tx.valid && r) rq.push_back(tx.data);
    end
    @(negedge clock);
    tx_ready <= 1'b0;
  endtask : get
endmodule : mcf_host_model

// file: test/mcf_frame_handler_bench.sv
// Self-checking bench for the frame handler with host and execution models.
// Assumes a 50 MHz clock and the gap limit cut to 20 cycles.
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module mcf_frame_handler_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic can_mode = 1'b0;
  logic motor_moving = 1'b0;
  logic exec_done = 1'b0;
  logic [7:0] exec_status = 8'h00;
  logic [31:0] exec_value = 32'h0000_0000;
  logic [7:0] module_addr = 8'h03;
  logic [7:0] reply_addr = 8'h02;
  int bad_count = 0;
  int comparisons = 0;
  int reqs = 0;
  logic [7:0] fq[$];
  logic [7:0] eq[$];
  mcf_pkg::mcf_byte_t rx;
  mcf_pkg::mcf_byte_t tx;
  logic tx_ready;
  logic tx_enable;
  logic exec_req;
  mcf_pkg::mcf_core_t exec_core;
  logic [7:0] standby_current;
  logic motor_idle_current_sel;
  always #10 clock = ~clock;
  mcf_frame_handler #(
    .GAP_LIMIT(20)
  ) i_mcf_frame_handler (
    .clock(clock), .srst(srst), .can_mode(can_mode), .module_addr(module_addr),
    .reply_addr(reply_addr), .rx(rx), .tx(tx), .tx_ready(tx_ready), .tx_enable(tx_enable),
    .exec_req(exec_req), .exec_core(exec_core), .exec_done(exec_done),
    .exec_status(exec_status), .exec_value(exec_value), .standby_current(standby_current),
    .motor_idle_current_sel(motor_idle_current_sel), .motor_moving(motor_moving)
  );
  mcf_host_model i_mcf_host_model (.clock(clock), .rx(rx), .tx(tx), .tx_ready(tx_ready));
  // Execution unit answers two cycles after each request.
  always @(negedge clock) if (exec_req) begin
    reqs++;
    repeat (2) @(negedge clock);
    exec_done <= 1'b1;
    exec_status <= mcf_pkg::ST_BAD_CMD;
    exec_value <= 32'hCAFE_0001;
    @(negedge clock);
    exec_done <= 1'b0;
    exec_status <= 8'hFD;
    exec_value <= 32'h3501_FFFE;
  end
  task automatic mk(input logic [7:0] a, c, st, input logic [31:0] v, rv, input logic bad);
    logic [7:0] s;
    logic [7:0] r;
    s = 8'h00;
    r = 8'h00;
    fq = {a, c, mcf_pkg::PAR_STANDBY, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0]};
    eq = {reply_addr, module_addr, st, c, rv[31:24], rv[23:16], rv[15:8], rv[7:0]};
    foreach (fq[i]) s += fq[i];
    foreach (eq[i]) r += eq[i];
    fq.push_back(s ^ {7'h00, bad});
    eq.push_back(r);
    if (can_mode) fq = fq[1:7];
    if (can_mode) eq = eq[1:7];
  endtask : mk
  task automatic xfer(input bit slow, input int n);
    i_mcf_host_model.send(fq);
    i_mcf_host_model.get(eq.size(), slow);
    `CHK("reply length", eq.size(), i_mcf_host_model.rq.size())
    if (i_mcf_host_model.rq.size() < eq.size()) tally_and_finish();
    for (int i = 0; i < n; i++) `CHK("reply byte", eq[i], i_mcf_host_model.rq[i])
  endtask : xfer
  task automatic t_standby(input logic [31:0] v);
    mk(module_addr, mcf_pkg::CMD_SET_AXIS, mcf_pkg::ST_OK, v, v, 1'b0);
    xfer(1'b1, eq.size());
    `CHK("standby", v[7:0], standby_current)
    mk(module_addr, mcf_pkg::CMD_SET_AXIS, mcf_pkg::ST_BAD_VALUE, 32'h100, 32'h100, 1'b0);
    xfer(1'b0, eq.size());
    mk(module_addr, mcf_pkg::CMD_GET_AXIS, mcf_pkg::ST_OK, 32'h0, v, 1'b0);
    xfer(1'b0, eq.size());
    motor_moving <= ~motor_moving;
    @(negedge clock);
    `CHK("idle select", ~motor_moving, motor_idle_current_sel)
  endtask : t_standby
  task automatic t_exec;
    mk(module_addr, 8'h01, mcf_pkg::ST_BAD_CSUM, 32'h1_0000, 32'h1_0000, 1'b1);
    xfer(1'b0, eq.size());
    `CHK("requests", 0, reqs)
    mk(module_addr, 8'h01, mcf_pkg::ST_BAD_CMD, 32'h1_0000, 32'hCAFE_0001, 1'b0);
    xfer(1'b1, eq.size());
    `CHK("requests", 1, reqs)
    `CHK("core", {8'h01, 8'h07, 8'h00, 32'h0001_0000}, exec_core)
  endtask : t_exec
  task automatic t_drop;
    logic [7:0] en;
    en = 8'h00;
    mk(8'h09, mcf_pkg::CMD_GET_AXIS, mcf_pkg::ST_OK, 32'h0, 32'hFF, 1'b0);
    i_mcf_host_model.send(fq);
    repeat (40) @(negedge clock) en += {7'h00, tx_enable};
    `CHK("silent", 8'h00, en)
    mk(module_addr, mcf_pkg::CMD_GET_AXIS, mcf_pkg::ST_OK, 32'h0, 32'hFF, 1'b0);
    i_mcf_host_model.send(fq[0:3]);
    repeat (30) @(negedge clock);
    xfer(1'b0, eq.size());
  endtask : t_drop
  task automatic t_can;
    can_mode = 1'b1;
    t_standby(32'h0000_0032);
    can_mode = 1'b0;
  endtask : t_can
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(negedge clock);
    srst = 1'b0;
    `CHK("standby reset", mcf_pkg::STANDBY_RST, standby_current)
    `CHK("enable reset", 1'b0, tx_enable)
    t_standby(32'h0000_00FF);
    t_exec();
    t_drop();
    t_can();
    tally_and_finish();
  end
endmodule : mcf_frame_handler_bench
bind mcf_frame_handler mcf_frame_sva i_mcf_frame_sva (
  .clock(clock), .srst(srst), .rx(rx), .tx(tx), .tx_ready(tx_ready), .tx_enable(tx_enable),
  .exec_req(exec_req), .exec_done(exec_done), .standby_current(standby_current),
  .motor_idle_current_sel(motor_idle_current_sel), .motor_moving(motor_moving)
);
